// *** logic/ddr_defines.vh ***
// Purpose: constants for the dither routing control block
// Assumes: commands arrive as 4-bit code plus 16-bit data on a plain register port
// Notes: command codes double as register addresses
//
// Summary of operation
// RL1 - Select commands choose dither source per channel
// RL2 - Sources may reach none or any channel subset
// RL3 - At most one source per channel
// RL4 - Scale settings quarter, half, three quarters, full
// RL5 - Separate scale setting held per channel
// RL6 - Invert command flips dither phase per channel
// RL7 - Settings change anytime without reset
// RL8 - Monitor select routes one channel out
// RL9 - Zero monitor select disables the monitor
// RL10 - Outputs clamped until span command written
// RL11 - Host configures dither before writing span
// RL12 - Reset: no dither, full scale, no invert
`ifndef DDR_DEFINES_VH
`define DDR_DEFINES_VH

// ----------------------------------------------------------------
// Command codes (register addresses)
// ----------------------------------------------------------------
`define DDR_CMD_MONITOR 4'h0
`define DDR_CMD_SPAN 4'h4
`define DDR_CMD_SRC_FIRST 4'h9
`define DDR_CMD_SRC_SECOND 4'ha
`define DDR_CMD_INVERT 4'hb
`define DDR_CMD_SCALE_LO 4'hc
`define DDR_CMD_SCALE_HI 4'hd
`define DDR_CMD_STATUS 4'hf

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define DDR_MON_SEL_W 5
`define DDR_SPAN_W 4
`define DDR_SCALE_QUARTER 2'h0
`define DDR_SCALE_HALF 2'h1
`define DDR_SCALE_THREEQ 2'h2
`define DDR_SCALE_FULL 2'h3
`define DDR_RST_SCALE 32'hffffffff
`define DDR_RST_SRC 16'h0000
`define DDR_RST_INVERT 16'h0000
`define DDR_RST_MON 5'h00
`define DDR_RST_SPAN 4'h0

`endif

// *** logic/ddr_scale_unit.v ***
// Purpose: scales and optionally inverts one dither sample
// Assumes: samples are signed two's complement
// Notes: purely combinational
`timescale 1ns/1ps
`include "ddr_defines.vh"

module ddr_scale_unit #(
	parameter W = 12
) (
	input wire signed [W-1:0] sample_in,
	input wire [1:0] scale,
	input wire invert,
	output reg signed [W-1:0] sample_out
);

	// ----------------------------------------------------------------
	// Scaling by shifts
	// ----------------------------------------------------------------
	wire signed [W+1:0] wide = {{2{sample_in[W-1]}}, sample_in};
	wire signed [W+1:0] half = wide >>> 1;
	wire signed [W+1:0] quarter = wide >>> 2;
	reg signed [W+1:0] scaled;

	// Quarter steps from shift sums, avoiding a multiplier
	always @* begin
		case (scale)
			`DDR_SCALE_QUARTER: scaled = quarter; // RL4
			`DDR_SCALE_HALF: scaled = half; // RL4
			`DDR_SCALE_THREEQ: scaled = half + quarter; // RL4
			default: scaled = wide; // RL4
		endcase
		// Negation of the most negative sample saturates instead of wrapping
		if (invert) begin
			scaled = -scaled; // RL6
		end
		if (scaled > $signed({3'b000, {(W-1){1'b1}}})) begin
			sample_out = {1'b0, {(W-1){1'b1}}};
		end else begin
			sample_out = scaled[W-1:0];
		end
	end

endmodule

// *** logic/ddr_dither_control.v ***
// Purpose: per-channel dither routing, scale, inversion, monitor mux and clamp
// Assumes: dither inputs and DAC codes are already digital on sys_clk
// Notes: register write takes effect the cycle after the strobe
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ddr_defines.vh"

module ddr_dither_control #(
	parameter CH = 16,
	parameter W = 12
) (
	input wire sys_clk,
	input wire reset,
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata,
	input wire [W-1:0] dither_input_first,
	input wire [W-1:0] dither_input_second,
	input wire [CH*W-1:0] dac_code,
	output reg [CH*W-1:0] dac_out,
	output reg [CH-1:0] out_clamp,
	output reg [W-1:0] monitor_out,
	output reg monitor_enable
);

	// ----------------------------------------------------------------
	// Configuration state
	// ----------------------------------------------------------------
	reg [CH-1:0] src_first;
	reg [CH-1:0] src_second;
	reg [CH-1:0] invert;
	reg [2*CH-1:0] scale;
	reg [`DDR_MON_SEL_W-1:0] monitor_channel_select;
	reg [`DDR_SPAN_W-1:0] span;
	reg span_written;

	// Writes apply live at any time; no mode change needed
	always @(posedge sys_clk) begin
		if (reset) begin
			src_first <= `DDR_RST_SRC; // RL12
			src_second <= `DDR_RST_SRC; // RL12
			invert <= `DDR_RST_INVERT; // RL12
			scale <= `DDR_RST_SCALE; // RL12
			monitor_channel_select <= `DDR_RST_MON; // RL12
			span <= `DDR_RST_SPAN;
			span_written <= 1'b0;
		end else if (wr) begin
			case (addr)
				`DDR_CMD_MONITOR: monitor_channel_select <= wdata[`DDR_MON_SEL_W-1:0]; // RL8
				`DDR_CMD_SPAN: begin
					span <= wdata[`DDR_SPAN_W-1:0];
					span_written <= 1'b1; // RL10
				end
				// Selecting one source drops the other on those channels
				`DDR_CMD_SRC_FIRST: begin
					src_first <= wdata; // RL1 RL2
					src_second <= src_second & ~wdata; // RL3
				end
				`DDR_CMD_SRC_SECOND: begin
					src_second <= wdata; // RL1 RL2
					src_first <= src_first & ~wdata; // RL3
				end
				`DDR_CMD_INVERT: invert <= wdata; // RL6 RL7
				`DDR_CMD_SCALE_LO: scale[15:0] <= wdata; // RL5 RL7
				`DDR_CMD_SCALE_HI: scale[31:16] <= wdata; // RL5 RL7
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read port, data one cycle after strobe
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				`DDR_CMD_MONITOR: rdata <= {11'h000, monitor_channel_select};
				`DDR_CMD_SPAN: rdata <= {12'h000, span};
				`DDR_CMD_SRC_FIRST: rdata <= src_first;
				`DDR_CMD_SRC_SECOND: rdata <= src_second;
				`DDR_CMD_INVERT: rdata <= invert;
				`DDR_CMD_SCALE_LO: rdata <= scale[15:0];
				`DDR_CMD_SCALE_HI: rdata <= scale[31:16];
				`DDR_CMD_STATUS: rdata <= {15'h0000, span_written};
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel dither path
	// ----------------------------------------------------------------
	wire [CH*W-1:0] scaled_dither;
	genvar g;
	generate
		for (g = 0; g < CH; g = g + 1) begin : gen_ch
			// Priority to the first source keeps the output single-sourced
			wire [W-1:0] chosen = src_first[g] ? dither_input_first : dither_input_second; // RL3
			ddr_scale_unit #(.W(W)) u_scale (
				.sample_in(chosen),
				.scale(scale[2*g+1:2*g]),
				.invert(invert[g]),
				.sample_out(scaled_dither[g*W +: W])
			);
		end
	endgenerate

	// Adds dither to the DAC code; wraps are the host's responsibility
	function [W-1:0] mix;
		input [W-1:0] code;
		input [W-1:0] dith;
		input en;
		begin
			mix = en ? code + dith : code;
		end
	endfunction

	// Outputs clamped to zero until the span is configured
	integer i;
	always @(posedge sys_clk) begin
		if (reset) begin
			dac_out <= {CH*W{1'b0}};
			out_clamp <= {CH{1'b1}};
		end else begin
			for (i = 0; i < CH; i = i + 1) begin
				if (!span_written) begin
					dac_out[i*W +: W] <= {W{1'b0}}; // RL10
				end else begin
					dac_out[i*W +: W] <= mix(dac_code[i*W +: W], scaled_dither[i*W +: W],
						src_first[i] | src_second[i]); // RL1
				end
			end
			out_clamp <= {CH{~span_written}}; // RL10
		end
	end

	// ----------------------------------------------------------------
	// Monitor multiplexer; select n+1 picks channel n, zero disables
	// ----------------------------------------------------------------
	wire [`DDR_MON_SEL_W-1:0] mon_idx = monitor_channel_select - 5'h01;
	always @(posedge sys_clk) begin
		if (reset) begin
			monitor_out <= {W{1'b0}};
			monitor_enable <= 1'b0;
		end else if (monitor_channel_select == 5'h00 || mon_idx >= CH) begin
			monitor_out <= {W{1'b0}}; // RL9
			monitor_enable <= 1'b0; // RL9
		end else begin
			monitor_out <= dac_out[mon_idx[3:0]*W +: W]; // RL8
			monitor_enable <= 1'b1; // RL8
		end
	end

endmodule

// *** sim/ddr_host_model.sv ***
// Purpose: host that issues dither commands
// Assumes: strobes change just after a rising edge
// Notes: call idle to drop strobes
`timescale 1ns/1ps
module ddr_host_model (
	input wire sys_clk,
	output logic [3:0] addr = 4'h0,
	output logic [15:0] wdata = 16'h0,
	output logic wr = 1'b0,
	output logic rd = 1'b0
);
	// Strobe stays up so commands can run back to back
	task automatic put(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
	endtask
	task automatic get(input logic [3:0] a);
		@(posedge sys_clk);
		addr <= a;
		wdata <= ~wdata;
		rd <= 1'b1;
		wr <= 1'b0;
	endtask
	task automatic idle;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
endmodule

// *** sim/ddr_dither_control_sva.sv ***
// Purpose: port checks of the dither block
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ps
module ddr_dither_control_sva #(parameter CH = 16, parameter W = 12) (
	input wire sys_clk,
	input wire reset,
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	input wire [15:0] rdata,
	input wire [CH*W-1:0] dac_out,
	input wire [CH-1:0] out_clamp,
	input wire monitor_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence span_wr; wr && addr == 4'h4; endsequence
	sequence mon_wr; wr && addr == 4'h0; endsequence
	rst_state_a: assert property ($fell(reset) |-> !monitor_enable && dac_out == '0) else $error("bad reset state");
	clamp_reset_a: assert property ($fell(reset) |-> &out_clamp) else $error("not clamped");
	span_free_a: assert property (span_wr |-> ##2 out_clamp == '0) else $error("clamp kept");
	clamp_zero_a: assert property (out_clamp[0] |-> dac_out[W-1:0] == '0) else $error("clamped lane live");
	span_stat_a: assert property (span_wr ##1 (rd && addr == 4'hf) |=> rdata[0]) else $error("span status");
	mon_off_a: assert property (mon_wr ##0 wdata[4:0] == 5'h0 |-> ##2 !monitor_enable) else $error("mon on");
	mon_on_a: assert property (mon_wr ##0 wdata[4:0] inside {[1:16]} |-> ##2 monitor_enable) else $error("mon off");
	one_src_a: assert property (wr && addr == 4'h9 ##1 rd && addr == 4'ha |=> (rdata & $past(wdata, 2)) == 16'h0)
		else $error("two sources");
endmodule
bind ddr_dither_control ddr_dither_control_sva #(.CH(CH), .W(W)) u_sva (.sys_clk(sys_clk), .reset(reset),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dac_out(dac_out), .out_clamp(out_clamp),
	.monitor_enable(monitor_enable));

// *** sim/ddr_dither_control_tb.sv ***
// Purpose: self-checking bench of the dither block
// Assumes: reads answer one cycle after the strobe
// Notes: dac lanes checked at all four scale settings
`timescale 1ns/1ps
module ddr_dither_control_tb;
	localparam int CH = 16;
	localparam int W = 12;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, q[$];
	logic wr, rd, mon_en, rd_d = 1'b0;
	logic [W-1:0] d1 = '0, d2 = '0, mon, ex[CH];
	logic signed [W-1:0] sq, sh;
	logic [CH*W-1:0] code = '0, dac;
	logic [CH-1:0] clamp;
	logic [3:0] ra[8] = '{4'h0, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf, 4'h1};
	logic [15:0] rv[8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0};
	int mn[5] = '{1, 2, 16, 0, 17};
	int n_fail = 0, checks = 0;
	always #25 sys_clk = ~sys_clk;
	ddr_host_model u_host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	ddr_dither_control #(.CH(CH), .W(W)) u_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .dither_input_first(d1), .dither_input_second(d2), .dac_code(code),
		.dac_out(dac), .out_clamp(clamp), .monitor_out(mon), .monitor_enable(mon_en));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdq(input logic [3:0] a, input logic [15:0] e);
		q.push_back(e);
		u_host.get(a);
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Read results land one cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_d) chk("rdata", q.pop_front(), rdata);
		rd_d <= rd;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		print_verdict;
	end
	initial begin
		logic [15:0] m, s;
		void'($urandom(69040));
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		code <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		d1 <= $urandom;
		d2 <= $urandom;
		chk("clamp", 16'hffff, clamp);
		foreach (ra[i]) rdq(ra[i], rv[i]);
		m = $urandom;
		s = $urandom;
		u_host.put(4'ha, s);
		u_host.put(4'h9, m);
		rdq(4'ha, s & ~m);
		rdq(4'h9, m);
		u_host.put(4'hb, s);
		rdq(4'hb, s);
		for (int k = 0; k < 4; k++) begin
			u_host.put(4'hd, {8{k[1:0]}});
			rdq(4'hd, {8{k[1:0]}});
		end
		// Dither set up before the span write to avoid output jumps
		u_host.put(4'h9, 16'h0001);
		u_host.put(4'ha, 16'h0002);
		u_host.put(4'hb, 16'h0002);
		u_host.put(4'hc, 16'hffff);
		u_host.put(4'h4, $urandom);
		rdq(4'hf, 16'h0001);
		u_host.idle;
		repeat (3) @(posedge sys_clk);
		foreach (ex[i]) ex[i] = code[i*W+:W];
		ex[0] = ex[0] + d1;
		// Inverting the most negative sample saturates one step short
		ex[1] = ex[1] + ((d2 == 12'h800) ? 12'h7ff : -d2);
		chk("clamp", 16'h0, clamp);
		foreach (ex[i]) chk("dac", 16'(ex[i]), 16'(dac[i*W+:W]));
		foreach (mn[i]) begin
			u_host.put(4'h0, 16'(mn[i]));
			u_host.idle;
			repeat (3) @(posedge sys_clk);
			chk("mon", (mn[i] inside {[1:16]}) ? 16'(ex[mn[i]-1]) : 16'h0, 16'(mon));
			chk("mon_en", 16'(mn[i] inside {[1:16]}), 16'(mon_en));
		end
		// Quarter, half and three-quarter steps on lanes 2 to 4
		u_host.put(4'h9, 16'h001d);
		u_host.put(4'hc, 16'hfe4f);
		u_host.idle;
		repeat (3) @(posedge sys_clk);
		sq = $signed(d1) >>> 2;
		sh = $signed(d1) >>> 1;
		ex[2] = ex[2] + sq;
		ex[3] = ex[3] + sh;
		ex[4] = ex[4] + sh + sq;
		foreach (ex[i]) chk("dac", 16'(ex[i]), 16'(dac[i*W+:W]));
		// Both sources dropped from every lane
		u_host.put(4'h9, 16'h0000);
		u_host.put(4'ha, 16'h0000);
		u_host.idle;
		repeat (3) @(posedge sys_clk);
		foreach (ex[i]) chk("dac", 16'(code[i*W+:W]), 16'(dac[i*W+:W]));
		print_verdict;
	end
endmodule
